// ===== hdl/qsp_pkg.sv
// Constants, field layouts and carrier types for the queued serial block.
// Assumes one system clock domain plus the slave link clock taken from the pin.
// What this block does
// - Serial operation only while the configuration-select field holds 0b00.
// - Every finished frame sets the transfer-complete flag.
// - Master drives six chip-select outputs to pick the addressed slave.
// - Leaves reset Stopped; Stopped starts no master frame, answers no slave frame.
// - Running-state bit is set while Running, clear while Stopped.
// - Enter Running when end-of-queue clear, halt clear, not frozen in debug.
// - Stop on end-of-queue, halt or debug freeze, at frame boundary.
// - Frames may be up to 32 bits long.
// - Master drives clock and selects; command picks attributes; head entry shifts out.
// - Slave answers external master only, attribute set zero, most significant bit first.
// - Bypass bits make each FIFO act as a one-entry buffer.
// - Transmit FIFO holds four entries, filled by pushes, emptied by shifting or flush.
// - Transmit count rises per push and falls per load into shifter.
// - Transmit next pointer advances per load and wraps after top entry.
// - Fill flag set while not full; cleared by DMA done or write one.
// - Writing one to flush empties the transmit FIFO.
// - Slave frame starting on empty transmit FIFO sets underflow flag.
// - Receive FIFO holds four frames; each finished frame not dropped on overflow enters it, count rises.
// - Pop pointer names next entry read and advances per pop, wrapping.
// - Start with FIFO and shifter full sets overflow; overwrite bit keeps or drops data.
// - Each pop lowers receive count; pop of empty FIFO changes nothing.
// - Drain flag set while not empty; cleared by DMA read done or write one.
// - Any write to the pop register raises a transfer error.
// - Drain request goes to DMA when select is one, interrupt when zero.
package qsp_pkg;
    localparam int WORD_W = 32;
    localparam int CS_W = 6;
    localparam int SYS_PERIOD_NS = 40;
    localparam int SCK_HALF_NS = 160;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [2:0] HALF_LAST = 3'(SCK_HALF_CYC - 1);
    localparam logic [1:0] CFG_SPI = 2'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_FULL = 3'h4;
    localparam logic [1:0] PTR_ONE = 2'h1;
    localparam logic [4:0] BIT_ONE = 5'h01;
    localparam logic [4:0] WORD_MSB = 5'h1f;
    localparam logic [2:0] ATTR_ZERO = 3'h0;
    localparam logic [CS_W-1:0] CS_IDLE = 6'h3f;
    localparam int CMD_CONT = 31;
    localparam int CMD_ATTR_HI = 30;
    localparam int CMD_ATTR_LO = 28;
    localparam int CMD_EOQ = 27;
    localparam int CMD_CS_HI = 21;
    localparam int CMD_CS_LO = 16;

    typedef struct packed {
        logic [4:0] frameMsb;
        logic cpol;
    } qsp_attr_t;

    typedef struct packed {
        logic [1:0] configSelect;
        logic masterMode;
        logic halt;
        logic debugMode;
        logic debugFreezeBit;
        logic txFifoBypass;
        logic rxFifoBypass;
        logic rxOverwriteEnable;
        logic rxDrainReqEnable;
        logic rxDrainRequestSelect;
    } qsp_ctrl_t;

    typedef struct packed {
        logic txFlushBit;
        logic txFillClear;
        logic txUnderflowClear;
        logic rxOverflowClear;
        logic rxDrainClear;
        logic xferCompleteClear;
        logic endOfQueueClear;
    } qsp_w1c_t;

    typedef struct packed {
        logic runningStateBit;
        logic transferCompleteFlag;
        logic endOfQueueFlag;
        logic txFillFlag;
        logic txUnderflowFlag;
        logic rxOverflowFlag;
        logic rxDrainFlag;
        logic [2:0] txEntryCount;
        logic [1:0] txNextPointer;
        logic [2:0] rxEntryCount;
        logic [1:0] popNextPointer;
    } qsp_status_t;

    typedef struct packed {
        logic serialClk;
        logic [CS_W-1:0] chipSelectOutN;
        logic serialDataOut;
    } qsp_mpins_t;

    typedef enum logic [2:0] {
        MST_IDLE = 3'h0,
        MST_SETUP = 3'h1,
        MST_LEAD = 3'h2,
        MST_TRAIL = 3'h3,
        MST_DONE = 3'h4
    } qsp_mst_t;

    typedef struct packed {
        logic [5:0] bitCnt;
        logic [WORD_W-1:0] shiftOut;
        logic [WORD_W-1:0] shiftIn;
        logic [WORD_W-1:0] rxWord;
        logic startToggle;
        logic doneToggle;
        logic dataOut;
    } qsp_link_t;
endpackage

// ===== hdl/qsp_run_fifo.sv
// Run control, master shifter, slave link and both FIFOs of the queued serial block.
// Assumes control inputs come from logic on sys_clk; link pins come from outside.
////////////////////////////////////////////////////////////////////////////////
module qsp_slave_link (
    // Link clock and reset
    input wire logic linkSck,
    input wire logic linkRst_n,
    // Pins
    input wire logic slaveSelectN,
    input wire logic serialDataIn,
    output logic slaveDataOut_q,
    // Toward the system domain
    input wire logic [qsp_pkg::WORD_W-1:0] txWord,
    input wire logic [4:0] frameMsb,
    output logic startToggle_q,
    output logic doneToggle_q,
    output logic [qsp_pkg::WORD_W-1:0] rxWord_q
);
    import qsp_pkg::*;
    qsp_link_t l_q;
    qsp_link_t l_d;

    always_comb begin
        l_d = l_q;
        if (slaveSelectN) begin
            l_d.bitCnt = '0;
        end else begin
            if (l_d.bitCnt == '0) begin
                l_d.startToggle = ~l_q.startToggle;
                l_d.shiftOut = txWord << (WORD_MSB - frameMsb);
                l_d.shiftIn = '0;
            end
            l_d.dataOut = l_d.shiftOut[WORD_W-1];
            l_d.shiftOut = {l_d.shiftOut[WORD_W-2:0], 1'b0};
            l_d.shiftIn = {l_d.shiftIn[WORD_W-2:0], serialDataIn};
            if (l_q.bitCnt[4:0] == frameMsb) begin
                l_d.rxWord = l_d.shiftIn;
                l_d.doneToggle = ~l_q.doneToggle;
                l_d.bitCnt = '0;
            end else begin
                l_d.bitCnt = l_q.bitCnt + 6'h01;
            end
        end
    end

    always_ff @(posedge linkSck) begin
        if (!linkRst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign slaveDataOut_q = l_q.dataOut;
    assign startToggle_q = l_q.startToggle;
    assign doneToggle_q = l_q.doneToggle;
    assign rxWord_q = l_q.rxWord;
endmodule // qsp_slave_link

////////////////////////////////////////////////////////////////////////////////
module qsp_run_fifo (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Control and attribute sets
    input wire qsp_pkg::qsp_ctrl_t ctrl,
    input wire qsp_pkg::qsp_attr_t attrSet0,
    input wire qsp_pkg::qsp_attr_t attrSet1,
    input wire qsp_pkg::qsp_w1c_t cmd,
    // Push side
    input wire logic pushValid,
    input wire logic [qsp_pkg::WORD_W-1:0] pushData,
    input wire logic pushDmaDone,
    // Pop side
    input wire logic popRead,
    input wire logic popWrite,
    input wire logic popDmaDone,
    output logic [qsp_pkg::WORD_W-1:0] popData_q,
    output logic xferError_q,
    // Status and requests
    output qsp_pkg::qsp_status_t status_q,
    output logic rxDrainDmaReq_q,
    output logic rxDrainIrqReq_q,
    // Master pins
    output qsp_pkg::qsp_mpins_t masterPins_q,
    input wire logic serialDataIn,
    // Slave link
    input wire logic linkSck,
    input wire logic slaveSelectN,
    output logic slaveDataOut_q
);
    import qsp_pkg::*;

    typedef struct packed {
        qsp_mst_t mst;
        logic [2:0] halfCnt;
        logic [4:0] bitCnt;
        logic [4:0] frameMsb;
        logic cpol;
        logic cont;
        logic eoq;
        logic [WORD_W-1:0] shiftOut;
        logic [WORD_W-1:0] shiftIn;
        logic [3:0][WORD_W-1:0] txMem;
        logic [1:0] txWr;
        logic [3:0][WORD_W-1:0] rxMem;
        logic [1:0] rxWr;
        logic [WORD_W-1:0] rxHold;
        logic rxHoldValid;
        logic rxDiscard;
        logic slvBusy;
        logic [WORD_W-1:0] slvTx;
        logic sdiS1;
        logic sdiS2;
        logic [2:0] stSync;
        logic [2:0] dnSync;
        logic linkRstN;
        qsp_status_t status;
        qsp_mpins_t pins;
        logic [WORD_W-1:0] popData;
        logic xferError;
        logic dmaReq;
        logic irqReq;
    } qsp_sys_t;

    qsp_sys_t s_q;
    qsp_sys_t s_d;
    logic startToggle;
    logic doneToggle;
    logic [WORD_W-1:0] linkRxWord;
    logic stopReq;
    logic txFull;
    logic rxFull;
    logic txTake;
    logic rxStart;
    logic rxDone;
    logic [WORD_W-1:0] rxIn;
    logic [WORD_W-1:0] head;
    qsp_attr_t attrSel;

    qsp_slave_link link (
        .linkSck(linkSck),
        .linkRst_n(s_q.linkRstN),
        .slaveSelectN(slaveSelectN),
        .serialDataIn(serialDataIn),
        .slaveDataOut_q(slaveDataOut_q),
        .txWord(s_q.slvTx),
        .frameMsb(attrSet0.frameMsb),
        .startToggle_q(startToggle),
        .doneToggle_q(doneToggle),
        .rxWord_q(linkRxWord)
    );

    assign stopReq = s_q.status.endOfQueueFlag | ctrl.halt | (ctrl.debugMode & ctrl.debugFreezeBit)
                     | (ctrl.configSelect != CFG_SPI);
    assign txFull = s_q.status.txEntryCount >= (ctrl.txFifoBypass ? CNT_ONE : CNT_FULL);
    assign rxFull = s_q.status.rxEntryCount >= (ctrl.rxFifoBypass ? CNT_ONE : CNT_FULL);
    assign head = s_q.txMem[s_q.status.txNextPointer];
    assign attrSel = (head[CMD_ATTR_HI:CMD_ATTR_LO] == ATTR_ZERO) ? attrSet0 : attrSet1;

    always_comb begin
        s_d = s_q;
        txTake = 1'b0;
        rxStart = 1'b0;
        rxDone = 1'b0;
        rxIn = '0;
        s_d.linkRstN = 1'b1;
        s_d.sdiS1 = serialDataIn;
        s_d.sdiS2 = s_q.sdiS1;
        s_d.stSync = {s_q.stSync[1:0], startToggle};
        s_d.dnSync = {s_q.dnSync[1:0], doneToggle};
        if (clkEn) begin
            s_d.xferError = popWrite;
            // Run control
            if (!s_q.status.runningStateBit) begin
                s_d.status.runningStateBit = !stopReq;
            end else if (stopReq && s_q.mst == MST_IDLE && !s_q.slvBusy) begin
                s_d.status.runningStateBit = 1'b0;
            end
            // Master sequencer
            s_d.halfCnt = s_q.halfCnt + 3'h1;
            case (s_q.mst)
                MST_IDLE: begin
                    s_d.halfCnt = '0;
                    if (s_q.status.runningStateBit && !stopReq && ctrl.masterMode
                        && s_q.status.txEntryCount != '0) begin
                        txTake = 1'b1;
                        rxStart = 1'b1;
                        s_d.frameMsb = attrSel.frameMsb;
                        s_d.cpol = attrSel.cpol;
                        s_d.cont = head[CMD_CONT];
                        s_d.eoq = head[CMD_EOQ];
                        s_d.shiftOut = {head[15:0], 16'h0000} << (WORD_MSB - attrSel.frameMsb - 5'h10);
                        s_d.shiftIn = '0;
                        s_d.bitCnt = '0;
                        s_d.pins.serialClk = attrSel.cpol;
                        s_d.pins.chipSelectOutN = ~head[CMD_CS_HI:CMD_CS_LO];
                        s_d.mst = MST_SETUP;
                    end
                end
                MST_SETUP, MST_LEAD: begin
                    s_d.pins.serialDataOut = s_q.shiftOut[WORD_W-1];
                    if (s_q.halfCnt == HALF_LAST) begin
                        s_d.halfCnt = '0;
                        s_d.pins.serialClk = ~s_q.cpol;
                        s_d.shiftIn = {s_q.shiftIn[WORD_W-2:0], s_q.sdiS2};
                        s_d.mst = MST_TRAIL;
                    end
                end
                MST_TRAIL: begin
                    if (s_q.halfCnt == HALF_LAST) begin
                        s_d.halfCnt = '0;
                        s_d.pins.serialClk = s_q.cpol;
                        s_d.shiftOut = {s_q.shiftOut[WORD_W-2:0], 1'b0};
                        if (s_q.bitCnt == s_q.frameMsb) begin
                            s_d.mst = MST_DONE;
                        end else begin
                            s_d.bitCnt = s_q.bitCnt + BIT_ONE;
                            s_d.mst = MST_LEAD;
                        end
                    end
                end
                MST_DONE: begin
                    rxDone = 1'b1;
                    rxIn = s_q.shiftIn;
                    s_d.status.transferCompleteFlag = 1'b1;
                    if (s_q.eoq) begin
                        s_d.status.endOfQueueFlag = 1'b1;
                    end
                    if (!s_q.cont) begin
                        s_d.pins.chipSelectOutN = CS_IDLE;
                    end
                    s_d.mst = MST_IDLE;
                end
                default: begin
                    s_d.mst = MST_IDLE;
                end
            endcase
            // Slave frames seen through the link
            if (s_q.stSync[2] != s_q.stSync[1] && s_q.status.runningStateBit && !ctrl.masterMode) begin
                s_d.slvBusy = 1'b1;
                rxStart = 1'b1;
                if (s_q.status.txEntryCount == '0) begin
                    s_d.status.txUnderflowFlag = 1'b1;
                end else begin
                    txTake = 1'b1;
                end
            end
            if (s_q.dnSync[2] != s_q.dnSync[1] && s_q.slvBusy) begin
                s_d.slvBusy = 1'b0;
                rxDone = 1'b1;
                rxIn = linkRxWord;
                s_d.status.transferCompleteFlag = 1'b1;
            end
            // Software clears; a same-cycle set wins, except for underflow when its flag is already set
            if (cmd.xferCompleteClear && !rxDone) begin
                s_d.status.transferCompleteFlag = 1'b0;
            end
            if (cmd.endOfQueueClear && !(rxDone && s_q.eoq && s_q.mst == MST_DONE)) begin
                s_d.status.endOfQueueFlag = 1'b0;
            end
            if (cmd.txUnderflowClear && !(s_d.status.txUnderflowFlag && !s_q.status.txUnderflowFlag)) begin
                s_d.status.txUnderflowFlag = 1'b0;
            end
            // Transmit FIFO
            if (txTake) begin
                s_d.status.txEntryCount = s_d.status.txEntryCount - CNT_ONE;
                s_d.status.txNextPointer = s_q.status.txNextPointer + PTR_ONE;
            end
            if (pushValid && !txFull) begin
                s_d.txMem[s_q.txWr] = pushData;
                s_d.txWr = s_q.txWr + PTR_ONE;
                s_d.status.txEntryCount = s_d.status.txEntryCount + CNT_ONE;
            end
            if (cmd.txFlushBit) begin
                s_d.status.txEntryCount = '0;
                s_d.status.txNextPointer = '0;
                s_d.txWr = '0;
            end
            if (!txFull) begin
                s_d.status.txFillFlag = 1'b1;
            end else if (pushDmaDone || cmd.txFillClear) begin
                s_d.status.txFillFlag = 1'b0;
            end
            s_d.slvTx = (s_d.status.txEntryCount != '0) ? s_d.txMem[s_d.status.txNextPointer] : '0;
            // Receive FIFO
            if (popRead && s_q.status.rxEntryCount != '0) begin
                s_d.popData = s_q.rxMem[s_q.status.popNextPointer];
                s_d.status.popNextPointer = s_q.status.popNextPointer + PTR_ONE;
                s_d.status.rxEntryCount = s_q.status.rxEntryCount - CNT_ONE;
            end
            if (rxStart && rxFull && s_q.rxHoldValid) begin
                s_d.status.rxOverflowFlag = 1'b1;
                s_d.rxDiscard = !ctrl.rxOverwriteEnable;
            end else if (cmd.rxOverflowClear) begin
                s_d.status.rxOverflowFlag = 1'b0;
            end
            if (s_d.rxHoldValid && s_d.status.rxEntryCount < (ctrl.rxFifoBypass ? CNT_ONE : CNT_FULL)) begin
                s_d.rxMem[s_q.rxWr] = s_q.rxHold;
                s_d.rxWr = s_q.rxWr + PTR_ONE;
                s_d.status.rxEntryCount = s_d.status.rxEntryCount + CNT_ONE;
                s_d.rxHoldValid = 1'b0;
            end
            if (rxDone) begin
                if (s_q.rxDiscard) begin
                    s_d.rxDiscard = 1'b0;
                end else if (!s_d.rxHoldValid
                             && s_d.status.rxEntryCount < (ctrl.rxFifoBypass ? CNT_ONE : CNT_FULL)) begin
                    s_d.rxMem[s_d.rxWr] = rxIn;
                    s_d.rxWr = s_d.rxWr + PTR_ONE;
                    s_d.status.rxEntryCount = s_d.status.rxEntryCount + CNT_ONE;
                end else begin
                    s_d.rxHold = rxIn;
                    s_d.rxHoldValid = 1'b1;
                end
            end
            if (s_q.status.rxEntryCount != '0) begin
                s_d.status.rxDrainFlag = 1'b1;
            end else if (popDmaDone || cmd.rxDrainClear) begin
                s_d.status.rxDrainFlag = 1'b0;
            end
            s_d.dmaReq = ctrl.rxDrainReqEnable && ctrl.rxDrainRequestSelect && s_q.status.rxDrainFlag;
            s_d.irqReq = ctrl.rxDrainReqEnable && !ctrl.rxDrainRequestSelect && s_q.status.rxDrainFlag;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.pins.chipSelectOutN <= CS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_q = s_q.status;
    assign popData_q = s_q.popData;
    assign xferError_q = s_q.xferError;
    assign rxDrainDmaReq_q = s_q.dmaReq;
    assign rxDrainIrqReq_q = s_q.irqReq;
    assign masterPins_q = s_q.pins;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence seqLoad;
        clkEn && txTake && !cmd.txFlushBit;
    endsequence
    sequence seqFrameEnd;
        clkEn && s_q.mst == MST_DONE;
    endsequence

    chk_stopped_idle: assert property (!s_q.status.runningStateBit && s_q.mst == MST_IDLE |=> s_q.mst == MST_IDLE)
        else $error("master frame started while stopped");
    chk_run_entry: assert property (clkEn && !s_q.status.runningStateBit && !stopReq
                                    |=> s_q.status.runningStateBit)
        else $error("did not enter running");
    chk_run_exit: assert property (clkEn && s_q.status.runningStateBit && stopReq && s_q.mst == MST_IDLE
                                   && !s_q.slvBusy |=> !s_q.status.runningStateBit)
        else $error("did not stop");
    chk_frame_done: assert property (seqFrameEnd |=> s_q.status.transferCompleteFlag)
        else $error("frame end without complete flag");
    chk_load_ptr: assert property (seqLoad |=> s_q.status.txNextPointer == $past(s_q.status.txNextPointer) + PTR_ONE)
        else $error("next pointer did not advance");
    chk_tx_flush: assert property (clkEn && cmd.txFlushBit
                                   |=> s_q.status.txEntryCount == '0 && s_q.status.txNextPointer == '0)
        else $error("flush left entries");
    chk_push_count: assert property (clkEn && pushValid && !txFull && !txTake && !cmd.txFlushBit
                                     |=> s_q.status.txEntryCount == $past(s_q.status.txEntryCount) + CNT_ONE)
        else $error("push did not count");
    chk_full_ignore: assert property (clkEn && pushValid && txFull && !txTake && !cmd.txFlushBit
                                      |=> $stable(s_q.status.txEntryCount))
        else $error("push into full FIFO changed count");
    chk_pop_empty: assert property (clkEn && popRead && s_q.status.rxEntryCount == '0 && !rxDone
                                    && !s_q.rxHoldValid |=> s_q.status.rxEntryCount == '0)
        else $error("pop of empty FIFO changed count");
    chk_pop_write: assert property (clkEn && popWrite |=> xferError_q ##1 (xferError_q == $past(popWrite)))
        else $error("pop write without transfer error");
endmodule // qsp_run_fifo

// ===== dv/qsp_ext_master.sv
// External serial master that drives the slave link of the block.
// Assumes the slave samples and drives on the rising link clock.
module qsp_ext_master (
    // Link pins
    output logic linkSck,
    output logic slaveSelectN,
    output logic serialDataIn,
    input wire logic slaveDataOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rxWord;
    initial begin
        linkSck = 1'b0;
        slaveSelectN = 1'b1;
        serialDataIn = 1'b0;
        rxWord = 32'h0;
    end
    // One link clock pulse; the select line is left as it is
    task automatic idleEdge();
        #32 linkSck = 1'b1;
        #32 linkSck = 1'b0;
    endtask
    // A full 32-bit frame, then one more clock pulse with the slave deselected
    task automatic frame(input logic [31:0] w);
        slaveSelectN = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            serialDataIn = w[i];
            idleEdge();
            rxWord = {rxWord[30:0], slaveDataOut};
        end
        slaveSelectN = 1'b1;
        serialDataIn = ~serialDataIn;
        idleEdge();
    endtask
endmodule // qsp_ext_master

// ===== dv/qsp_run_fifo_tb.sv
// Self-checking bench for the run control and FIFOs, slave operation.
// Assumes the external master model drives the link pins.
module qsp_run_fifo_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import qsp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    qsp_ctrl_t ctrl = '0;
    qsp_attr_t attrSet0 = '{frameMsb: 5'h1f, cpol: 1'b0};
    qsp_w1c_t cmd = '0;
    logic pushValid = 1'b0;
    logic popRead = 1'b0;
    logic popWrite = 1'b0;
    logic [31:0] pushData = 32'h0;
    logic [31:0] popData;
    logic xferError;
    qsp_status_t st;
    qsp_mpins_t mPins;
    logic linkSck;
    logic slaveSelectN;
    logic serialDataIn;
    logic slaveDataOut;
    int n_fail = 0;
    int comparisons = 0;
    qsp_run_fifo u_qsp_run_fifo (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .ctrl(ctrl),
        .attrSet0(attrSet0), .attrSet1(attrSet0), .cmd(cmd), .pushValid(pushValid), .pushData(pushData),
        .pushDmaDone(1'b0), .popRead(popRead), .popWrite(popWrite), .popDmaDone(1'b0), .popData_q(popData),
        .xferError_q(xferError), .status_q(st), .rxDrainDmaReq_q(), .rxDrainIrqReq_q(), .masterPins_q(mPins),
        .serialDataIn(serialDataIn), .linkSck(linkSck), .slaveSelectN(slaveSelectN), .slaveDataOut_q(slaveDataOut));
    qsp_ext_master u_qsp_ext_master (.linkSck(linkSck), .slaveSelectN(slaveSelectN),
        .serialDataIn(serialDataIn), .slaveDataOut(slaveDataOut));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [31:0] w);
        pushData <= w;
        pushValid <= 1'b1;
        @(posedge sys_clk);
        pushValid <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        repeat (3) @(posedge sys_clk);
        chk(st.runningStateBit, 32'h1);
        chk(st.txFillFlag, 32'h1);
        chk(mPins.chipSelectOutN, 32'h3f);
        $display("test reset done");
    endtask
    task automatic test_fill();
        ctrl.halt <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(st.runningStateBit, 32'h0);
        for (int i = 0; i < 5; i++) push(32'ha0 + i);
        chk(st.txEntryCount, 32'h4);
        chk(st.txFillFlag, 32'h1);
        cmd.txFillClear <= 1'b1;
        @(posedge sys_clk);
        cmd <= '0;
        repeat (2) @(posedge sys_clk);
        chk(st.txFillFlag, 32'h0);
        cmd.txFlushBit <= 1'b1;
        @(posedge sys_clk);
        cmd <= '0;
        repeat (2) @(posedge sys_clk);
        chk({st.txEntryCount, st.txNextPointer}, 32'h0);
        $display("test fill done");
    endtask
    task automatic test_frame();
        ctrl.halt <= 1'b0;
        push(32'hc3a5_0f96);
        u_qsp_ext_master.frame(32'h5a12_e0c7);
        repeat (8) @(posedge sys_clk);
        chk(u_qsp_ext_master.rxWord, 32'hc3a5_0f96);
        chk(st.transferCompleteFlag, 32'h1);
        chk({st.txEntryCount, st.txNextPointer}, 32'h1);
        chk(st.rxEntryCount, 32'h1);
        for (int i = 0; i < 2; i++) begin
            popRead <= 1'b1;
            @(posedge sys_clk);
            popRead <= 1'b0;
            repeat (2) @(posedge sys_clk);
            chk(popData, 32'h5a12_e0c7);
            chk({st.rxEntryCount, st.popNextPointer}, 32'h1);
        end
        popWrite <= 1'b1;
        @(posedge sys_clk);
        popWrite <= 1'b0;
        @(negedge sys_clk);
        chk(xferError, 32'h1);
        @(negedge sys_clk);
        chk(xferError, 32'h0);
        @(posedge sys_clk);
        $display("test frame done");
    endtask
    task automatic test_flags();
        u_qsp_ext_master.frame(32'h0);
        repeat (8) @(posedge sys_clk);
        chk(st.txUnderflowFlag, 32'h1);
        for (int i = 0; i < 5; i++) u_qsp_ext_master.frame(32'h11 * i);
        repeat (8) @(posedge sys_clk);
        chk(st.rxOverflowFlag, 32'h1);
        chk(st.rxEntryCount, 32'h4);
        chk(st.rxDrainFlag, 32'h1);
        $display("test flags done");
    endtask
    initial begin
        #100us;
        n_fail++;
        give_verdict();
    end
    initial begin
        fork
            begin
                u_qsp_ext_master.idleEdge();
                u_qsp_ext_master.idleEdge();
            end
            repeat (12) @(posedge sys_clk);
        join
        chk(st.runningStateBit, 32'h0);
        rst_n <= 1'b1;
        test_reset();
        test_fill();
        test_frame();
        test_flags();
        give_verdict();
    end
endmodule // qsp_run_fifo_tb
